// [xdata_arbiter_flash_remap.sv]
// Memory arbiter with DMA bus ownership handshake and flash boot sector remap.
`timescale 1ns/1ps
`default_nettype none
module xdata_arbiter_flash_remap (
  input wire logic clock,
  input wire logic rstn,
  input wire arb_pkg::sfr_req_t sfr,
  output logic [7:0] sfr_rdata_r,
  input wire arb_pkg::prog_req_t prog,
  input wire logic dma_req,
  input wire logic dma_done,
  input wire logic isr_active,
  input wire logic isr_high,
  input wire logic [7:0] flash_rdata,
  output logic dma_interrupt_line_r,
  output logic dma_ownership_grant_r,
  output logic dma_owns_xdata_r,
  output logic sram_sel_r,
  output logic flash_sel_r,
  output logic [18:0] flash_addr_r,
  output logic [7:0] prog_rdata_r,
  output logic erase_done_r,
  output logic prog_done_r,
  output arb_pkg::flash_cmd_t flash_cmd_r,
  output logic flash_armed_r
);
  import arb_pkg::*;

  logic req_r;
  logic remap_r;
  logic prog_wr_en_r;
  logic [18:0] phys_addr;
  logic in_win;
  logic in_sram;
  logic wr_win;
  logic wr_direct;
  logic [7:0] prog_wdata_r;
  logic prog_pending_r;
  logic [7:0] read_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode: low 16KB to SRAM, next 16KB folded when remap is on.
  assign in_sram = (prog.addr[18:14] == 5'h00);
  assign in_win = remap_r && (prog.addr[18:14] == {3'h0, page_win});
  always_comb begin
    phys_addr = prog.addr;
    if (in_win) begin
      phys_addr = {5'h00, prog.addr[13:0] & win_mask};
    end
  end
  assign wr_win = prog.wr && prog_wr_en_r && in_win;
  assign wr_direct = prog.wr && prog_wr_en_r && !in_sram && !in_win;

  // Routing of each program access, registered toward the memories.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sram_sel_r <= 1'b0;
      flash_sel_r <= 1'b0;
      flash_addr_r <= '0;
      prog_rdata_r <= 8'h00;
    end else begin
      sram_sel_r <= (prog.rd | prog.wr) && in_sram;
      flash_sel_r <= (prog.rd | prog.wr) && !in_sram;
      flash_addr_r <= phys_addr;
      prog_rdata_r <= flash_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request flag; the request wins over a completion in the same cycle.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_r <= arb_reg_reset[req_bit];
    end else if (dma_req) begin
      req_r <= 1'b1;
    end else if (dma_done) begin
      req_r <= 1'b0;
    end
  end

  // Grant is write-one only; completion clears it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma_ownership_grant_r <= arb_reg_reset[grant_bit];
    end else if (sfr.wr && sfr.addr == arb_reg_addr && sfr.wdata[grant_bit]) begin
      dma_ownership_grant_r <= 1'b1;
    end else if (dma_done) begin
      dma_ownership_grant_r <= 1'b0;
    end
  end

  // DMA owns xDATA only with request and grant both set.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma_owns_xdata_r <= 1'b0;
    end else begin
      dma_owns_xdata_r <= req_r && dma_ownership_grant_r && !dma_done;
    end
  end

  // Interrupt raised while a request waits; a busy high-priority ISR holds it pending.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma_interrupt_line_r <= 1'b0;
    end else begin
      dma_interrupt_line_r <= req_r && !dma_ownership_grant_r
                              && !(isr_active && isr_high);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System registers holding remap enable and program write enable.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      remap_r <= csr_reset[remap_bit];
    end else if (sfr.wr && sfr.addr == csr_addr) begin
      remap_r <= sfr.wdata[remap_bit];
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prog_wr_en_r <= pwr_ctrl_reset[prog_wr_en_bit];
    end else if (sfr.wr && sfr.addr == pwr_ctrl_addr) begin
      prog_wr_en_r <= sfr.wdata[prog_wr_en_bit];
    end
  end

  // Register readback.
  always_comb begin
    read_mux = 8'h00;
    case (sfr.addr)
      arb_reg_addr: read_mux = {dma_ownership_grant_r, 6'h00, req_r};
      csr_addr: read_mux = {5'h00, remap_r, 2'h0};
      pwr_ctrl_addr: read_mux = {3'h0, prog_wr_en_r, 4'h0};
      default: read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sfr_rdata_r <= 8'h00;
    end else if (sfr.rd) begin
      sfr_rdata_r <= read_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Completion status from flash reads; program done needs a program command first, erase done needs none.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      prog_pending_r <= 1'b0;
      prog_wdata_r <= 8'h00;
      erase_done_r <= 1'b0;
      prog_done_r <= 1'b0;
    end else begin
      erase_done_r <= flash_sel_r && flash_addr_r[13:0] == win_mask
                      && flash_rdata == erased_byte;
      prog_done_r <= prog_pending_r && flash_sel_r && flash_rdata == prog_wdata_r;
      if (flash_cmd_r.prog) begin
        prog_pending_r <= 1'b1;
        prog_wdata_r <= flash_cmd_r.data;
      end else if (prog_done_r) begin
        prog_pending_r <= 1'b0;
      end
    end
  end

  // Flash command sequence decoding.
  flash_cmd_seq u_seq (
    .clock(clock),
    .rstn(rstn),
    .wr_win(wr_win),
    .wr_direct(wr_direct),
    .flash_addr(phys_addr),
    .wdata(prog.wdata),
    .prog_wr_en(prog_wr_en_r),
    .cmd_r(flash_cmd_r),
    .armed_r(flash_armed_r)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on request, grant, ownership, interrupt and address map behaviour.
  property p_grant_needed;
    @(posedge clock) disable iff (!rstn)
    dma_owns_xdata_r |-> $past(dma_ownership_grant_r) && $past(req_r);
  endproperty
  a_grant_needed: assert property (p_grant_needed) else $error("DMA owns bus without grant");

  property p_done_clears;
    @(posedge clock) disable iff (!rstn)
    dma_done && !dma_req |=> !req_r && !dma_ownership_grant_r;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("Completion left flags set");

  property p_req_sets;
    @(posedge clock) disable iff (!rstn)
    dma_req |=> req_r;
  endproperty
  a_req_sets: assert property (p_req_sets) else $error("Request flag not set");

  property p_irq;
    @(posedge clock) disable iff (!rstn)
    req_r && !dma_ownership_grant_r && !isr_active |=> dma_interrupt_line_r;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not raised");

  property p_no_preempt;
    @(posedge clock) disable iff (!rstn)
    isr_active && isr_high |=> !dma_interrupt_line_r;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("High priority ISR preempted");

  property p_zero_write;
    @(posedge clock) disable iff (!rstn)
    !dma_ownership_grant_r && !(sfr.wr && sfr.addr == arb_reg_addr && sfr.wdata[grant_bit])
      |=> !dma_ownership_grant_r;
  endproperty
  a_zero_write: assert property (p_zero_write) else $error("Grant set without write one");

  property p_sram_low;
    @(posedge clock) disable iff (!rstn)
    (prog.rd || prog.wr) && prog.addr[18:14] == 5'h00 |=> sram_sel_r && !flash_sel_r;
  endproperty
  a_sram_low: assert property (p_sram_low) else $error("Low program space left SRAM");

  property p_remap;
    @(posedge clock) disable iff (!rstn)
    remap_r && prog.rd && prog.addr[18:14] == 5'h01 |=> flash_addr_r[18:14] == 5'h00;
  endproperty
  a_remap: assert property (p_remap) else $error("Window not folded to boot sector");

  property p_direct;
    @(posedge clock) disable iff (!rstn)
    !remap_r && prog.rd && prog.addr[18:14] == 5'h01 |=> flash_addr_r[18:14] == 5'h01;
  endproperty
  a_direct: assert property (p_direct) else $error("Direct mapping broken");
endmodule
`default_nettype wire

// [arb_pkg.sv]
// Package with the arbiter's register map, field positions and shared types.
package arb_pkg;
  localparam logic [7:0] arb_reg_addr = 8'h9a;
  localparam logic [7:0] csr_addr = 8'h8f;
  localparam logic [7:0] pwr_ctrl_addr = 8'h87;
  localparam int req_bit = 0;
  localparam int grant_bit = 7;
  localparam int remap_bit = 2;
  localparam int prog_wr_en_bit = 4;
  localparam logic [7:0] arb_reg_reset = 8'h00;
  localparam logic [7:0] csr_reset = 8'h00;
  localparam logic [7:0] pwr_ctrl_reset = 8'h00;
  localparam logic [13:0] win_mask = 14'h3fff;
  localparam logic [13:0] unlock_a = 14'h0555;
  localparam logic [13:0] unlock_b = 14'h02aa;
  localparam logic [13:0] erase_ofs = 14'h0000;
  localparam logic [7:0] key_aa = 8'haa;
  localparam logic [7:0] key_55 = 8'h55;
  localparam logic [7:0] cmd_erase_setup = 8'h80;
  localparam logic [7:0] cmd_sector_erase = 8'h30;
  localparam logic [7:0] cmd_byte_prog = 8'ha0;
  localparam logic [7:0] erased_byte = 8'hff;
  localparam logic [1:0] page_sram = 2'h0;
  localparam logic [1:0] page_win = 2'h1;

  // Special-function register access from the CPU core.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  // Program memory access from the CPU core.
  typedef struct packed {
    logic rd;
    logic wr;
    logic [18:0] addr;
    logic [7:0] wdata;
  } prog_req_t;

  // Flash command issued toward the flash macro.
  typedef struct packed {
    logic erase;
    logic prog;
    logic [18:0] addr;
    logic [7:0] data;
  } flash_cmd_t;
endpackage

// [flash_cmd_seq.sv]
// Flash command sequencer decoding unlock, erase and byte-program write sequences.
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_seq (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wr_win,
  input wire logic wr_direct,
  input wire logic [18:0] flash_addr,
  input wire logic [7:0] wdata,
  input wire logic prog_wr_en,
  output arb_pkg::flash_cmd_t cmd_r,
  output logic armed_r
);
  import arb_pkg::*;

  typedef enum logic [3:0] {
    s_idle, s_u1, s_u2, s_e3, s_e4, s_e5, s_armed
  } seq_t;

  seq_t state_r;
  seq_t state_nxt;
  logic [13:0] ofs;
  logic any_wr;

  assign ofs = flash_addr[13:0];
  assign any_wr = wr_win | wr_direct;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode; a wrong write returns the sequence to idle.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      s_idle: if (wr_win) begin
        state_nxt = (ofs == unlock_a && wdata == key_aa) ? s_u1 : s_idle;
      end
      s_u1: if (any_wr) begin
        state_nxt = (wr_win && ofs == unlock_b && wdata == key_55) ? s_u2 : s_idle;
      end
      s_u2: if (any_wr) begin
        if (wr_win && ofs == unlock_a && wdata == cmd_byte_prog) begin
          state_nxt = s_armed;
        end else if (wr_win && ofs == unlock_a && wdata == cmd_erase_setup) begin
          state_nxt = s_e3;
        end else begin
          state_nxt = s_idle;
        end
      end
      s_e3: if (any_wr) begin
        state_nxt = (wr_win && ofs == unlock_a && wdata == key_aa) ? s_e4 : s_idle;
      end
      s_e4: if (any_wr) begin
        state_nxt = (wr_win && ofs == unlock_b && wdata == key_55) ? s_e5 : s_idle;
      end
      s_e5: if (any_wr) begin
        state_nxt = s_idle;
      end
      s_armed: if (any_wr) begin
        state_nxt = s_idle;
      end
      default: state_nxt = s_idle;
    endcase
    // Without the write enable the sequence is forced back to idle; flash reads still go through.
    if (!prog_wr_en) begin
      state_nxt = s_idle;
    end
  end

  // Sequence state.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r <= s_idle;
    end else begin
      state_r <= state_nxt;
    end
  end

  // One-cycle command pulses; the armed state survives a remap change.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cmd_r <= '0;
      armed_r <= 1'b0;
    end else begin
      cmd_r.erase <= prog_wr_en && state_r == s_e5 && wr_win && ofs == erase_ofs
                     && wdata == cmd_sector_erase;
      cmd_r.prog <= prog_wr_en && state_r == s_armed && any_wr;
      if (any_wr) begin
        cmd_r.addr <= flash_addr;
        cmd_r.data <= wdata;
      end
      armed_r <= (state_nxt == s_armed);
    end
  end
endmodule
`default_nettype wire

// [dma_flash_model.sv]
// Far-side model: a DMA engine and a behavioural flash macro.
`timescale 1ns/1ps
`default_nettype none
module dma_flash_model (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic owns,
  input wire logic [3:0] burst,
  input wire logic [18:0] flash_addr,
  input wire arb_pkg::flash_cmd_t flash_cmd,
  output logic dma_req,
  output logic dma_done,
  output logic [7:0] flash_rdata
);
  import arb_pkg::*;

  logic busy;
  logic [3:0] cnt;
  logic erased;
  logic [18:0] tgt;
  logic [7:0] val;
  // The engine moves data only while it owns the bus, burst plus one cycles.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dma_req <= 1'b0;
      dma_done <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
    end else begin
      dma_req <= start;
      dma_done <= 1'b0;
      if (start) busy <= 1'b1;
      if (busy && owns) begin
        if (cnt == burst) begin
          dma_done <= 1'b1;
          busy <= 1'b0;
          cnt <= 4'h0;
        end else cnt <= cnt + 4'h1;
      end
    end
  end
  // Flash cells; unerased cells read the inverse of the low address byte so a wrong map shows.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      erased <= 1'b0;
      tgt <= 19'h7ffff;
      val <= 8'h00;
    end else begin
      if (flash_cmd.erase) erased <= 1'b1;
      if (flash_cmd.prog) begin
        tgt <= flash_cmd.addr;
        val <= flash_cmd.data;
      end
    end
  end
  assign flash_rdata = (flash_addr == tgt) ? val : erased ? 8'hff : ~flash_addr[7:0];
endmodule
`default_nettype wire

// [tb_xdata_arbiter_flash_remap.sv]
// Self-checking bench for the memory arbiter and flash remap window.
`timescale 1ns/1ps
`default_nettype none
module tb_xdata_arbiter_flash_remap;
  import arb_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  sfr_req_t sfr = '0;
  prog_req_t prog = '0;
  logic isr_active = 1'b0;
  logic isr_high = 1'b0;
  logic start = 1'b0;
  logic dma_req, dma_done, irq, grant, owns, sram_sel, flash_sel, edone, pdone, armed;
  logic [7:0] sfr_rdata, prog_rdata, flash_rdata;
  logic [18:0] flash_addr;
  flash_cmd_t cmd, last_prog;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_erase = 0;
  int n_prog = 0;
  int n_edone = 0;
  int n_pdone = 0;
  always #12.5 clock = ~clock;
  xdata_arbiter_flash_remap dut (.clock(clock), .rstn(rstn), .sfr(sfr),
    .sfr_rdata_r(sfr_rdata), .prog(prog), .dma_req(dma_req), .dma_done(dma_done),
    .isr_active(isr_active), .isr_high(isr_high), .flash_rdata(flash_rdata),
    .dma_interrupt_line_r(irq), .dma_ownership_grant_r(grant), .dma_owns_xdata_r(owns),
    .sram_sel_r(sram_sel), .flash_sel_r(flash_sel), .flash_addr_r(flash_addr),
    .prog_rdata_r(prog_rdata), .erase_done_r(edone), .prog_done_r(pdone),
    .flash_cmd_r(cmd), .flash_armed_r(armed));
  dma_flash_model far (.clock(clock), .rstn(rstn), .start(start), .owns(owns),
    .burst(4'h5), .flash_addr(flash_addr), .flash_cmd(cmd), .dma_req(dma_req),
    .dma_done(dma_done), .flash_rdata(flash_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  // Pulses are counted at the edge after they are launched.
  always @(posedge clock) begin
    if (cmd.erase === 1'b1) n_erase++;
    if (cmd.prog === 1'b1) begin
      n_prog++;
      last_prog = cmd;
    end
    if (edone === 1'b1) n_edone++;
    if (pdone === 1'b1) n_pdone++;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // Strobes go up just after an edge and drop after the edge that takes them.
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick(1);
    sfr = '0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    tick(1);
    sfr = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    sfr = '0;
    chk(sfr_rdata, exp);
  endtask
  // One program access, then the chosen memory and, for flash accesses only, the flash address are compared.
  task automatic pacc(input logic w, input logic [18:0] a, input logic [7:0] d,
                      input logic [18:0] fa, input logic to_sram);
    tick(1);
    prog = '{rd: ~w, wr: w, addr: a, wdata: d};
    tick(1);
    prog = '0;
    chk(sram_sel, to_sram);
    chk(flash_sel, !to_sram);
    if (!to_sram) chk(flash_addr, fa);
  endtask
  task automatic erase_seq();
    logic [13:0] ofs [6];
    logic [7:0] dat [6];
    ofs = '{14'h0555, 14'h02aa, 14'h0555, 14'h0555, 14'h02aa, 14'h0000};
    dat = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55, 8'h30};
    for (int i = 0; i < 6; i++) pacc(1'b1, 19'h04000 + ofs[i], dat[i], ofs[i], 1'b0);
  endtask
  task automatic unlock();
    pacc(1'b1, 19'h04555, 8'haa, 19'h00555, 1'b0);
    pacc(1'b1, 19'h042aa, 8'h55, 19'h002aa, 1'b0);
    pacc(1'b1, 19'h04555, 8'ha0, 19'h00555, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // The whole run needs well under a thousand cycles.
  initial begin
    #100000;
    n_mismatch++;
    tally_and_finish();
  end
  // The bench plays the CPU and its firmware.
  initial begin
    tick(4);
    rstn = 1'b1;
    sfr_rd(8'h9a, 8'h00);
    sfr_rd(8'h8f, 8'h00);
    isr_active = 1'b1;
    isr_high = 1'b1;
    tick(1);
    start = 1'b1;
    tick(1);
    start = 1'b0;
    tick(5);
    chk(irq, 1'b0);
    sfr_rd(8'h9a, 8'h01);
    sfr_wr(8'h9a, 8'h00);
    chk(grant, 1'b0);
    chk(owns, 1'b0);
    isr_active = 1'b0;
    tick(3);
    chk(irq, 1'b1);
    sfr_wr(8'h9a, 8'h80);
    chk(grant, 1'b1);
    chk(owns, 1'b0);
    // The interrupt line and ownership follow the grant one edge later.
    tick(1);
    chk(irq, 1'b0);
    chk(owns, 1'b1);
    pacc(1'b0, 19'h00200, 8'h00, 19'h0, 1'b1);
    tick(8);
    sfr_rd(8'h9a, 8'h00);
    chk(owns, 1'b0);
    pacc(1'b0, 19'h00100, 8'h00, 19'h0, 1'b1);
    pacc(1'b0, 19'h04123, 8'h00, 19'h04123, 1'b0);
    sfr_wr(8'h8f, 8'h04);
    sfr_rd(8'h8f, 8'h04);
    pacc(1'b0, 19'h04123, 8'h00, 19'h00123, 1'b0);
    pacc(1'b0, 19'h00010, 8'h00, 19'h0, 1'b1);
    erase_seq();
    chk(n_erase, 0);
    sfr_wr(8'h87, 8'h10);
    erase_seq();
    tick(1);
    chk(n_erase, 1);
    pacc(1'b0, 19'h07fff, 8'h00, 19'h03fff, 1'b0);
    tick(3);
    chk(n_edone, 1);
    unlock();
    pacc(1'b1, 19'h04123, 8'h3c, 19'h00123, 1'b0);
    tick(1);
    chk(n_prog, 1);
    chk(last_prog.addr, 19'h00123);
    chk(last_prog.data, 8'h3c);
    pacc(1'b0, 19'h04123, 8'h00, 19'h00123, 1'b0);
    tick(1);
    chk(prog_rdata, 8'h3c);
    tick(2);
    chk(n_pdone, 1);
    unlock();
    sfr_wr(8'h8f, 8'h00);
    chk(armed, 1'b1);
    pacc(1'b1, 19'h05000, 8'h77, 19'h05000, 1'b0);
    tick(1);
    chk(n_prog, 2);
    chk(last_prog.addr, 19'h05000);
    chk(last_prog.data, 8'h77);
    sfr_wr(8'h87, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire
